// [hdl/clock_source_select_status_regs.vh]
`ifndef CLOCK_SOURCE_SELECT_STATUS_REGS_VH
`define CLOCK_SOURCE_SELECT_STATUS_REGS_VH
// Register byte offsets.
`define OSC_ENABLE_CMD_OFS 8'h20
`define CLOCK_COMMAND_OFS 8'h24
`define LOW_FREQ_CLOCK_SELECT_OFS 8'h28
`define CLOCK_STATUS_OFS 8'h2C
`define CLOCK_INTERRUPT_FLAGS_OFS 8'h30
`define CLOCK_INTERRUPT_FLAG_SET_OFS 8'h34
`define CLOCK_INTERRUPT_FLAG_CLEAR_OFS 8'h38
`define CLOCK_INTERRUPT_ENABLE_OFS 8'h3C
`define CALIBRATION_TOP_VALUE_OFS 8'h1C
// Command register fields.
`define CMD_MAIN_SEL_LSB 0
`define CMD_CAL_GO_BIT 3
`define CMD_CAL_HALT_BIT 4
`define CMD_USB_SEL_LSB 5
// Main clock source codes.
`define MAIN_SRC_FAST_RC 3'h1
`define MAIN_SRC_FAST_XTAL 3'h2
`define MAIN_SRC_SLOW_RC 3'h3
`define MAIN_SRC_SLOW_XTAL 3'h4
`define MAIN_SRC_USB_RC_HALF 3'h5
// USB core clock source codes.
`define USB_SRC_SLOW_XTAL 3'h2
`define USB_SRC_SLOW_RC 3'h3
`define USB_SRC_USB_RC 3'h4
// Low frequency select fields.
`define LF_A_LSB 0
`define LF_B_LSB 2
`define LF_C_LSB 4
`define LF_A_EXT_BIT 16
`define LF_B_EXT_BIT 20
`define LF_FIELD_RESET 2'h1
// Status bit positions.
`define ST_CAL_RUNNING_BIT 14
`define ST_MAIN_SEL_LSB 10
`define ST_USB_SEL_LSB 16
`define ST_USB_RC_HALF_BIT 26
`define ST_USB_RC_ENS_BIT 21
`define ST_USB_RC_RDY_BIT 22
// Interrupt flag positions.
`define IF_CAL_DONE_BIT 5
`define IF_CAL_OVF_BIT 6
`define IF_USB_RC_RDY_BIT 8
`define IF_FAST_RC_RDY_BIT 0
`define IF_MASK 10'h37F
`define IF_RESET 10'h001
// Oscillator start-up time in ns and the cycle count it gives at the clock period.
// The count is kept as a sized literal so that it fits the 8-bit start-up counter.
`define STARTUP_NS 2000
`define CLK_PERIOD_NS 20
`define STARTUP_CYCLES 8'h64
// Clock switch settle time in cycles.
`define SWITCH_CYCLES 4'h4
`endif

// [hdl/clock_source_select_status.v]
`timescale 1ns/1ns
`include "clock_source_select_status_regs.vh"

// Start-up timer for one oscillator: ready rises after the start-up delay.
// The enable bit follows the write-one on and off commands, and the ready bit
// rises only once the timer has counted a full start-up period of cycles.
// Dropping the enable clears both at the next edge, so a restart always waits
// the whole period again; a short off pulse earns no credit.
module osc_startup (
  input wire clk,
  input wire rst_b,
  input wire reset_on,
  input wire en_cmd,
  input wire dis_cmd,
  output reg enabled_r,
  output reg ready_r,
  output wire ready_pulse
);
  reg [7:0] cnt_r;
  wire [7:0] startup_cycles;
  wire enabled_nxt;

  // The count is a sized constant, so the compare below loses no bits.
  assign startup_cycles = `STARTUP_CYCLES;
  // Enable wins over disable when both are written together.
  // The reset_on kick turns the oscillator on without a software command.
  assign enabled_nxt = en_cmd | reset_on | (enabled_r & ~dis_cmd);
  // The counter holds the full count in the last cycle of the start-up period.
  assign ready_pulse = enabled_r & ~ready_r & (cnt_r == startup_cycles);

  // The counter freezes once ready is up, so it never wraps while enabled.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enabled_r <= 1'b0;
      ready_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      enabled_r <= enabled_nxt;
      // Ready and count clear together, so the next enable starts a fresh period.
      if (!enabled_nxt) begin
        ready_r <= 1'b0;
        cnt_r <= 8'h00;
      end else if (ready_pulse) begin
        // Ready is sticky while the enable stays up.
        ready_r <= 1'b1;
      end else if (!ready_r) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

module clock_source_select_status (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_r,
  input wire cal_ref_tick,
  output reg [2:0] main_clock_source_r,
  output reg [2:0] usb_core_clock_source_r,
  output wire [1:0] slow_clock_a_source,
  output wire [1:0] slow_clock_b_source,
  output wire [1:0] slow_clock_c_source,
  output wire slow_a_source_extension,
  output wire slow_b_source_extension,
  output wire irq
);
  // Oscillator order: 0 fast RC, 1 fast crystal, 2 aux RC, 3 slow RC, 4 slow crystal, 5 USB RC.
  // The same order is used for the enable command bit pairs and the status bit pairs,
  // so index g means one oscillator throughout this module.
  reg fast_rc_boot_r;
  wire [5:0] osc_en;
  wire [5:0] osc_rdy;
  wire [5:0] osc_rdy_pulse;
  wire [5:0] osc_en_cmd;
  wire [5:0] osc_dis_cmd;
  // Slow clock selection and calibration state.
  reg [21:0] lf_sel_r;
  reg [19:0] cal_top_r;
  reg [19:0] cal_cnt_r;
  reg cal_running_r;
  // Interrupt flags, their next value and their enables.
  reg [9:0] if_r;
  reg [9:0] if_nxt;
  reg [9:0] ien_r;
  // USB core switch in flight and the boot tracking of the fast RC.
  reg [2:0] usb_pending_r;
  reg [3:0] usb_wait_r;
  reg fast_rc_alive_r;
  // Combinational words for the status and read paths.
  reg [31:0] status;
  reg [31:0] rdata_nxt;
  // Decoded write strobes and command fields.
  wire cmd_wr;
  wire cal_go;
  wire cal_halt;
  wire cal_finish;
  wire cal_overflow;
  wire [2:0] main_req;
  wire [2:0] usb_req;
  genvar g;

  // The command register is write-only: each write acts once and leaves nothing stored
  // except the pending USB switch, so a later strobe cannot replay an old command.
  assign cmd_wr = wr & (addr == `CLOCK_COMMAND_OFS);
  assign main_req = wdata[`CMD_MAIN_SEL_LSB +: 3];
  assign usb_req = wdata[`CMD_USB_SEL_LSB +: 3];
  assign cal_go = cmd_wr & wdata[`CMD_CAL_GO_BIT];
  assign cal_halt = cmd_wr & wdata[`CMD_CAL_HALT_BIT];

  // Oscillator enable and disable commands arrive as write-one pairs.
  // Only the fast RC gets the kick in the first cycle after reset; the other
  // five stay off until software turns them on.
  generate
    for (g = 0; g < 6; g = g + 1) begin : osc
      assign osc_en_cmd[g] = wr & (addr == `OSC_ENABLE_CMD_OFS) & wdata[2 * g];
      assign osc_dis_cmd[g] = wr & (addr == `OSC_ENABLE_CMD_OFS) & wdata[2 * g + 1];
      osc_startup u_startup (
        .clk(clk),
        .rst_b(rst_b),
        .reset_on(g == 0 ? ~fast_rc_alive_r : 1'b0),
        .en_cmd(osc_en_cmd[g]),
        .dis_cmd(osc_dis_cmd[g]),
        .enabled_r(osc_en[g]),
        .ready_r(osc_rdy[g]),
        .ready_pulse(osc_rdy_pulse[g])
      );
    end
  endgenerate

  // The fast RC runs out of reset; it is kicked on by the first cycle after release.
  // Its timer starts from zero at that kick, so the boot bit stands in for enable
  // and ready until the timer reports ready or software turns the oscillator off.
  // Without it the status would show the running source as not ready for a while.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_rc_alive_r <= 1'b0;
      fast_rc_boot_r <= 1'b1;
    end else begin
      fast_rc_alive_r <= 1'b1;
      if (osc_rdy[0] || (osc_dis_cmd[0] && !osc_en_cmd[0])) begin
        fast_rc_boot_r <= 1'b0;
      end
    end
  end

  // Main and USB source selection; no check of readiness, a dead source stops the clock.
  // The main source switches at the write edge. The USB core source waits out the
  // switch time first, so its status bits move only once the new clock is running.
  // Codes outside the documented sets are ignored and leave the old source in place.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_clock_source_r <= `MAIN_SRC_FAST_RC;
      usb_core_clock_source_r <= 3'h0;
      usb_pending_r <= 3'h0;
      usb_wait_r <= 4'h0;
    end else begin
      if (cmd_wr && main_req >= `MAIN_SRC_FAST_RC && main_req <= `MAIN_SRC_USB_RC_HALF) begin
        // A disabled target is taken as well; the clock then stops until it is enabled.
        main_clock_source_r <= main_req;
      end
      if (cmd_wr && usb_req >= `USB_SRC_SLOW_XTAL && usb_req <= `USB_SRC_USB_RC) begin
        // A new request restarts the wait and drops any switch still pending.
        usb_pending_r <= usb_req;
        usb_wait_r <= `SWITCH_CYCLES;
      end else if (usb_wait_r == 4'h1) begin
        // Last wait cycle: the new clock runs now, so the source and status move.
        usb_core_clock_source_r <= usb_pending_r;
        usb_wait_r <= 4'h0;
      end else if (usb_wait_r != 4'h0) begin
        usb_wait_r <= usb_wait_r - 4'h1;
      end
    end
  end

  // Slow clock selectors with their extension bits.
  // The register keeps each bit at its own offset, so the read-back needs no
  // reshuffling; reserved bits between the fields are stored as zero.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Every selector field wakes up on the slow RC, with both extensions clear.
      lf_sel_r <= {16'h0000, `LF_FIELD_RESET, `LF_FIELD_RESET, `LF_FIELD_RESET};
    end else if (wr && addr == `LOW_FREQ_CLOCK_SELECT_OFS) begin
      lf_sel_r <= {1'b0, wdata[20], 3'h0, wdata[16], 10'h000, wdata[5:0]};
    end
  end
  // The selector outputs come straight from the register, so they change at the
  // write edge; the clock switch logic downstream does its own glitch-free handover.
  assign slow_clock_a_source = lf_sel_r[`LF_A_LSB +: 2];
  assign slow_clock_b_source = lf_sel_r[`LF_B_LSB +: 2];
  assign slow_clock_c_source = lf_sel_r[`LF_C_LSB +: 2];
  assign slow_a_source_extension = lf_sel_r[`LF_A_EXT_BIT];
  assign slow_b_source_extension = lf_sel_r[`LF_B_EXT_BIT];

  // Calibration down-counter clocked by reference ticks; a tick at zero ends the run.
  // A run of top value N therefore takes N + 1 ticks. The counter keeps its value
  // after a halt; the offset then reads back the stored top value again.
  assign cal_finish = cal_running_r & cal_ref_tick & (cal_cnt_r == 20'h00000);
  // A down-count from a loaded top value cannot overflow, so hardware never raises
  // this flag; software can still set it through the flag set register.
  assign cal_overflow = 1'b0;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_top_r <= 20'h00000;
      cal_cnt_r <= 20'h00000;
      cal_running_r <= 1'b0;
    end else begin
      if (wr && addr == `CALIBRATION_TOP_VALUE_OFS) begin
        cal_top_r <= wdata[19:0];
      end
      // Halt wins over go, so a combined write leaves the counter stopped.
      if (cal_halt) begin
        cal_running_r <= 1'b0;
      end else if (cal_go) begin
        // A new run always restarts from the stored top value.
        cal_cnt_r <= cal_top_r;
        cal_running_r <= 1'b1;
      end else if (cal_finish) begin
        cal_running_r <= 1'b0;
      end else if (cal_running_r && cal_ref_tick) begin
        // One decrement per reference tick while the run is busy.
        cal_cnt_r <= cal_cnt_r - 20'h00001;
      end
    end
  end

  // Flags: hardware events and set writes win over a clear in the same cycle.
  // A flag cleared in the cycle of its own event would otherwise lose the event
  // for good, which software could not tell from no event at all.
  always @* begin
    if_nxt = if_r;
    if (wr && addr == `CLOCK_INTERRUPT_FLAG_CLEAR_OFS) begin
      if_nxt = if_nxt & ~wdata[9:0];
    end
    if (wr && addr == `CLOCK_INTERRUPT_FLAG_SET_OFS) begin
      if_nxt = if_nxt | (wdata[9:0] & `IF_MASK);
    end
    // Hardware events come last, so they win over a clear written in the same cycle.
    if_nxt[4:0] = if_nxt[4:0] | {osc_rdy_pulse[2], osc_rdy_pulse[4], osc_rdy_pulse[3], osc_rdy_pulse[1],
      osc_rdy_pulse[0]};
    if_nxt[`IF_USB_RC_RDY_BIT] = if_nxt[`IF_USB_RC_RDY_BIT] | osc_rdy_pulse[5];
    if_nxt[`IF_CAL_DONE_BIT] = if_nxt[`IF_CAL_DONE_BIT] | cal_finish;
    if_nxt[`IF_CAL_OVF_BIT] = if_nxt[`IF_CAL_OVF_BIT] | cal_overflow;
  end

  // Flag and enable registers. The reset value has the fast RC ready flag set,
  // because that oscillator is already running when reset lets go.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      if_r <= `IF_RESET;
      ien_r <= 10'h000;
    end else begin
      if_r <= if_nxt;
      if (wr && addr == `CLOCK_INTERRUPT_ENABLE_OFS) begin
        // The reserved bit cannot be enabled, so it never raises a request.
        ien_r <= wdata[9:0] & `IF_MASK;
      end
    end
  end
  // The request is a plain level of any enabled flag; it drops as soon as software
  // clears the flag or its enable, with no extra cycle of delay.
  assign irq = |(if_r & ien_r);

  // Status word; the fast RC pair reads one out of reset until its timer takes over.
  // Every bit is derived live from the state above, so a read always sees the
  // values of the cycle in which the read strobe stands.
  always @* begin
    status = 32'h00000000;
    // Enable and ready pairs, one pair per oscillator.
    status[0] = osc_en[0] | fast_rc_boot_r;
    status[1] = osc_rdy[0] | fast_rc_boot_r;
    status[2] = osc_en[1];
    status[3] = osc_rdy[1];
    status[4] = osc_en[2];
    status[5] = osc_rdy[2];
    status[6] = osc_en[3];
    status[7] = osc_rdy[3];
    status[8] = osc_en[4];
    status[9] = osc_rdy[4];

    // One-hot main fast clock source, plus the USB RC half bit further up.
    status[`ST_MAIN_SEL_LSB] = (main_clock_source_r == `MAIN_SRC_FAST_RC);
    status[11] = (main_clock_source_r == `MAIN_SRC_FAST_XTAL);
    status[12] = (main_clock_source_r == `MAIN_SRC_SLOW_RC);
    status[13] = (main_clock_source_r == `MAIN_SRC_SLOW_XTAL);

    // Calibration busy while the down-counter runs.
    status[`ST_CAL_RUNNING_BIT] = cal_running_r;

    // USB core source bits, moved only when the switch lands.
    status[`ST_USB_SEL_LSB] = (usb_core_clock_source_r == `USB_SRC_SLOW_XTAL);
    status[17] = (usb_core_clock_source_r == `USB_SRC_SLOW_RC);
    status[18] = (usb_core_clock_source_r == `USB_SRC_USB_RC);
    status[`ST_USB_RC_ENS_BIT] = osc_en[5];
    status[`ST_USB_RC_RDY_BIT] = osc_rdy[5];
    status[`ST_USB_RC_HALF_BIT] = (main_clock_source_r == `MAIN_SRC_USB_RC_HALF);
  end

  // Read mux; unmapped and write-only offsets read zero.
  // The top value offset shows the live count while a run is busy and the stored
  // top value otherwise, so one offset serves both loading and reading back.
  always @* begin
    rdata_nxt = 32'h00000000;
    case (addr)
      `LOW_FREQ_CLOCK_SELECT_OFS: rdata_nxt = {10'h000, lf_sel_r};
      `CLOCK_STATUS_OFS: rdata_nxt = status;
      `CLOCK_INTERRUPT_FLAGS_OFS: rdata_nxt = {22'h000000, if_r};
      `CLOCK_INTERRUPT_ENABLE_OFS: rdata_nxt = {22'h000000, ien_r};
      `CALIBRATION_TOP_VALUE_OFS: rdata_nxt = {12'h000, cal_running_r ? cal_cnt_r : cal_top_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  // Zero between reads keeps stale data off the bus and makes a lost strobe visible.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rd ? rdata_nxt : 32'h00000000;
    end
  end
endmodule

// [testbench/clock_source_select_status_chk.sv]
`timescale 1ns/1ns
// Checks the register port and the clock source outputs of the selection block.
module clock_source_select_status_chk (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata_r,
  input wire cal_ref_tick,
  input wire [2:0] main_clock_source_r,
  input wire [2:0] usb_core_clock_source_r,
  input wire [1:0] slow_clock_a_source,
  input wire [1:0] slow_clock_b_source,
  input wire [1:0] slow_clock_c_source,
  input wire slow_a_source_extension,
  input wire slow_b_source_extension,
  input wire irq
);
  // Decoded strides and the packed slow clock selection, for brevity below.
  wire cmd_wr = wr && addr == 8'h24;
  wire lf_wr = wr && addr == 8'h28;
  wire [7:0] lf_bits = {slow_b_source_extension, slow_a_source_extension, slow_clock_c_source,
    slow_clock_b_source, slow_clock_a_source};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // The main source follows only codes one to five.
  a_main_sel_taken: assert property (cmd_wr && wdata[2:0] inside {[1:5]} |=>
    main_clock_source_r == $past(wdata[2:0])) else $error("main source not taken");
  a_main_sel_refused: assert property (cmd_wr && !(wdata[2:0] inside {[1:5]}) |=>
    $stable(main_clock_source_r)) else $error("main source changed on bad code");
  // The USB switch lands four cycles after the write, not at once.
  a_usb_switch_delay: assert property (cmd_wr && wdata[7:5] == 3'h4 && usb_core_clock_source_r != 3'h4 |=>
    (usb_core_clock_source_r != 3'h4) [*2] ##[1:3] usb_core_clock_source_r == 3'h4)
    else $error("USB source switch timing wrong");
  a_status_source: assert property (rd && addr == 8'h2C |=>
    rdata_r[10] == ($past(main_clock_source_r) == 3'h1) && rdata_r[26] == ($past(main_clock_source_r) == 3'h5)
    && rdata_r[18] == ($past(usb_core_clock_source_r) == 3'h4)) else $error("status source bits wrong");
  a_slow_sel_taken: assert property (lf_wr |=>
    lf_bits == {$past(wdata[20]), $past(wdata[16]), $past(wdata[5:0])}) else $error("slow select not taken");
  a_slow_sel_held: assert property (!lf_wr |=> $stable(lf_bits)) else $error("slow select drifted");
  a_flag_set_read: assert property (wr && addr == 8'h34 ##1 rd && addr == 8'h30 |=>
    (rdata_r[9:0] & $past(wdata[9:0], 2) & 10'h37F) == ($past(wdata[9:0], 2) & 10'h37F))
    else $error("flag set not seen");
  a_flag_clear_read: assert property (wr && addr == 8'h38 ##1 rd && addr == 8'h30 |=>
    (rdata_r[9:0] & $past(wdata[9:0], 2) & 10'h37F) == 10'h000) else $error("flag clear not seen");
endmodule

bind clock_source_select_status clock_source_select_status_chk chk (.clk, .rst_b, .addr, .wdata, .wr, .rd,
  .rdata_r, .cal_ref_tick, .main_clock_source_r, .usb_core_clock_source_r, .slow_clock_a_source,
  .slow_clock_b_source, .slow_clock_c_source, .slow_a_source_extension, .slow_b_source_extension, .irq);

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, cal_ref_tick = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, v;
  logic [2:0] em = 3'h1;
  wire [31:0] rdata_r;
  wire [2:0] main_clock_source_r, usb_core_clock_source_r;
  wire [1:0] slow_clock_a_source, slow_clock_b_source, slow_clock_c_source;
  wire slow_a_source_extension, slow_b_source_extension, irq;
  logic [31:0] lf_tab [4] = '{32'h00110000, 32'h0000002D, 32'h00000000, 32'h00100036};
  int n_errors = 0, n_checks = 0;

  clock_source_select_status uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .cal_ref_tick(cal_ref_tick), .main_clock_source_r(main_clock_source_r),
    .usb_core_clock_source_r(usb_core_clock_source_r), .slow_clock_a_source(slow_clock_a_source),
    .slow_clock_b_source(slow_clock_b_source), .slow_clock_c_source(slow_clock_c_source),
    .slow_a_source_extension(slow_a_source_extension), .slow_b_source_extension(slow_b_source_extension),
    .irq(irq));

  // Free running 50 MHz clock.
  initial forever #10 clk = ~clk;

  // Compares and counts; unknowns never match.
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Each access ends just after the edge that took it, so outputs are settled.
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata_r;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdr(a, v);
    chk(v & m, e);
  endtask
  // A write followed without a gap by a read, so set and clear are seen at once.
  task wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) {wr, rd, addr} <= {1'b0, 1'b1, 8'h30};
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata_r & m, e);
  endtask
  task ticks(input int n);
    @(posedge clk) cal_ref_tick <= 1'b1;
    repeat (n) @(posedge clk);
    cal_ref_tick <= 1'b0;
  endtask
  task conclude;
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk({main_clock_source_r, usb_core_clock_source_r, slow_clock_c_source, slow_clock_b_source,
      slow_clock_a_source, slow_b_source_extension, slow_a_source_extension, irq}, {3'h1, 3'h0, 6'h15, 3'h0});
    rchk(8'h2C, 32'hFFFFFFFF, 32'h00000403);
    rchk(8'h30, 32'h000003FF, 32'h00000001);
    rchk(8'h04, 32'hFFFFFFFF, 32'h00000000);
    // Every main code, with refused codes leaving the old source in place; disabled targets are still taken.
    for (int k = 0; k < 8; k++) begin
      wrr(8'h24, k);
      if (k >= 1 && k <= 5) em = k;
      chk(main_clock_source_r, em);
      rchk(8'h2C, 32'h04003C00, em == 3'h5 ? 32'h04000000 : 32'h00000400 << (em - 1));
    end
    // USB core sources; code 7 at the end is ignored.
    for (int k = 2; k < 5; k++) begin
      wrr(8'h24, k << 5);
      repeat (6) @(posedge clk);
      chk(usb_core_clock_source_r, k);
      rchk(8'h2C, 32'h00070000, 32'h00010000 << (k - 2));
    end
    wrr(8'h24, 32'h000000E0);
    repeat (6) @(posedge clk);
    chk(usb_core_clock_source_r, 3'h4);
    // Slow clock selectors, with both extensions.
    for (int k = 0; k < 4; k++) begin
      wrr(8'h28, lf_tab[k]);
      rchk(8'h28, 32'h0011003F, lf_tab[k]);
      chk({slow_b_source_extension, slow_a_source_extension, slow_clock_c_source, slow_clock_b_source,
        slow_clock_a_source}, {lf_tab[k][20], lf_tab[k][16], lf_tab[k][5:0]});
    end
    // Flag set and clear against one enabled source.
    wrr(8'h3C, 32'h00000020);
    chk(irq, 1'b0);
    wrrd(8'h34, 32'h00000060, 32'h00000060, 32'h00000060);
    chk(irq, 1'b1);
    wrrd(8'h38, 32'h00000020, 32'h00000060, 32'h00000040);
    chk(irq, 1'b0);
    // A run of three counts finishes on the fourth tick; a halted run never finishes.
    wrr(8'h1C, 32'h00000003);
    wrr(8'h24, 32'h00000008);
    rchk(8'h2C, 32'h00004000, 32'h00004000);
    ticks(3);
    rchk(8'h1C, 32'h000FFFFF, 32'h00000000);
    rchk(8'h30, 32'h00000020, 32'h00000000);
    ticks(1);
    rchk(8'h30, 32'h00000020, 32'h00000020);
    rchk(8'h2C, 32'h00004000, 32'h00000000);
    wrr(8'h38, 32'h00000020);
    wrr(8'h1C, 32'h00000002);
    wrr(8'h24, 32'h00000008);
    wrr(8'h24, 32'h00000010);
    ticks(4);
    rchk(8'h2C, 32'h00004000, 32'h00000000);
    rchk(8'h30, 32'h00000020, 32'h00000000);
    // Only the USB RC is switched on; the fast RC stays on throughout.
    wrr(8'h20, 32'h00000400);
    rchk(8'h2C, 32'h00600000, 32'h00200000);
    repeat (110) @(posedge clk);
    rchk(8'h2C, 32'h00600000, 32'h00600000);
    rchk(8'h30, 32'h00000100, 32'h00000100);
    rchk(8'h2C, 32'h00000003, 32'h00000003);
    conclude;
  end
endmodule
